/* File: rtl/prs_consts.svh */
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH
`define PRS_SYNC_STAGES 2
`define PRS_STRAP_W 6
`define PRS_STRAP_DEFAULT 6'h00
`define PRS_SRST_CYCLES_DEF 16
`define PRS_FUNC_CTRL_ADDR 6'h04
`define PRS_FUNC_CTRL_RESET_BIT 5
`define PRS_FUNC_CTRL_RESET 8'h41
`define PRS_RXCMD_DEFAULT 8'h00
`define PRS_PWR_RESET 2'h2
`define PRS_MARGIN_RESET 3'h0
`define PRS_APB_CTRL 12'h000
`define PRS_APB_STATUS 12'h004
`define PRS_APB_STRAP 12'h008
`define PRS_APB_BOARD 12'h00c
`endif

/* File: rtl/prs_pkg.sv */
package prs_pkg;
    typedef enum logic [1:0] {
        PRS_DEV_IDLE,
        PRS_DEV_SRST,
        PRS_DEV_RXCMD
    } prs_dev_state_type;
    typedef enum logic [1:0] {
        PRS_HOST_HOLD,
        PRS_HOST_RUN,
        PRS_HOST_WAIT
    } prs_host_state_type;
endpackage

/* File: rtl/prs_link_if.sv */
`timescale 1ns/1ps
interface prs_link_if;
    logic chip_reset_n;
    logic logic_reset_n;
    logic out_enable;
    logic [5:0] strap_o;
    logic [5:0] strap_oe;
    logic [5:0] strap_i;
    logic ulpi_direction;
    logic [7:0] ulpi_data_bus;
    logic ulpi_data_oe;
    logic srst_write;
    logic detect_loopback_req;
    logic tx_idle_req;
    logic compliance_req;
    logic rx_polarity_req;
    logic [1:0] power_select;
    logic [2:0] tx_level_margin;
    logic deemphasis_sel;
    logic rate_sel;
    logic tx_swing_sel;
    logic rx_term_ctrl;
    modport device (
        input chip_reset_n, logic_reset_n, out_enable, strap_o, strap_oe, srst_write,
        input detect_loopback_req, tx_idle_req, compliance_req, rx_polarity_req,
        input power_select, tx_level_margin, deemphasis_sel, rate_sel, tx_swing_sel,
        input rx_term_ctrl,
        output strap_i, ulpi_direction, ulpi_data_bus, ulpi_data_oe
    );
    modport host (
        output chip_reset_n, logic_reset_n, out_enable, strap_o, strap_oe, srst_write,
        output detect_loopback_req, tx_idle_req, compliance_req, rx_polarity_req,
        output power_select, tx_level_margin, deemphasis_sel, rate_sel, tx_swing_sel,
        output rx_term_ctrl,
        input strap_i, ulpi_direction, ulpi_data_bus, ulpi_data_oe
    );
endinterface

/* File: rtl/prs_rst_sync.sv */
`timescale 1ns/1ps
`include "prs_consts.svh"
module prs_rst_sync (
    input wire logic mclk,
    input wire logic arst_n,
    output logic srst_n
);
    logic [`PRS_SYNC_STAGES-1:0] sync_q;
    // ------------------------------------------------------------
    // Release synchroniser
    // ------------------------------------------------------------
    // Assertion is immediate; release reaches the logic on the second clean edge.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[`PRS_SYNC_STAGES-2:0], 1'b1}; // [RULE15]
        end
    end
    assign srst_n = sync_q[`PRS_SYNC_STAGES-1];
endmodule

/* File: rtl/prs_device.sv */
`timescale 1ns/1ps
`include "prs_consts.svh"
// Function
// [RULE1] Chip reset returns all state to initial.
// [RULE2] Host uses chip reset at power-on only; CTRL bit 0 lets software assert it again at any time.
// [RULE3] Host holds chip reset until supplies stable.
// [RULE4] Host drives straps before chip reset release.
// [RULE5] Straps captured at reset release, then held.
// [RULE6] Undriven straps default via internal pulls.
// [RULE7] Host drives fixed PIPE control levels in reset.
// [RULE8] Host drives de-emphasis and rate high.
// [RULE9] Host writes function control reset bit.
// [RULE10] Software reset spares ULPI logic and registers.
// [RULE11] Direction low during reset, then RX CMD.
// [RULE12] Host ignores data bus during reset.
// [RULE13] Host keeps output enable low at power-up.
// [RULE14] Output enable low disables all drivers.
// [RULE15] Reset release synchronised to the clock.
module prs_device #(
    parameter int SRST_CYCLES = `PRS_SRST_CYCLES_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    prs_link_if.device link,
    output logic [5:0] strap_cfg,
    output logic core_reset_n,
    output logic srst_busy
);
    if (SRST_CYCLES < 1 || SRST_CYCLES > 65535) begin : g_bad_cycles
        $error("SRST_CYCLES out of range");
    end

    typedef struct packed {
        prs_pkg::prs_dev_state_type st;
        logic [15:0] cnt;
        logic [5:0] strap;
        logic [7:0] rxcmd;
        logic dir;
        logic data_oe;
        logic [7:0] data;
        logic core_rst_n;
        logic [1:0] oe_sync;
        logic [5:0] strap_s1;
        logic [5:0] strap_s2;
        logic [1:0] wr_sync;
        logic wr_last;
        logic [2:0] run;
        logic dir_pin;
        logic busy;
    } prs_dev_type;

    logic chip_srst_n;
    logic logic_srst_n;
    logic all_srst_n;
    prs_dev_type s_q;
    prs_dev_type s_d;
    logic [5:0] strap_pad;

    // ------------------------------------------------------------
    // Reset synchronisers
    // ------------------------------------------------------------
    assign all_srst_n = rst_n & link.chip_reset_n;
    prs_rst_sync u_chip_sync (
        .mclk(mclk),
        .arst_n(all_srst_n),
        .srst_n(chip_srst_n)
    );
    prs_rst_sync u_logic_sync (
        .mclk(mclk),
        .arst_n(link.logic_reset_n),
        .srst_n(logic_srst_n)
    );

    // Pins float to the pull-down default where the host leaves them undriven.
    assign strap_pad = (link.strap_o & link.strap_oe) | (`PRS_STRAP_DEFAULT & ~link.strap_oe); // [RULE6]

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.oe_sync = {s_q.oe_sync[0], link.out_enable};
        s_d.strap_s1 = strap_pad;
        s_d.strap_s2 = s_q.strap_s1;
        s_d.wr_sync = {s_q.wr_sync[0], link.srst_write};
        s_d.wr_last = s_q.wr_sync[1];
        s_d.run = {s_q.run[1:0], 1'b1};
        // The samples need two edges to fill after release, so the latch stays open till then.
        if (s_q.run != 3'h7) begin
            s_d.strap = s_q.strap_s2; // [RULE5]
        end
        if (s_q.run[2] && s_q.st == prs_pkg::PRS_DEV_IDLE && !s_q.core_rst_n) begin
            s_d.core_rst_n = 1'b1;
        end
        s_d.data_oe = 1'b0;
        unique case (s_q.st)
            prs_pkg::PRS_DEV_IDLE: begin
                if (s_q.wr_sync[1] && !s_q.wr_last) begin
                    s_d.st = prs_pkg::PRS_DEV_SRST;
                    s_d.cnt = 16'(SRST_CYCLES);
                    s_d.core_rst_n = 1'b0; // [RULE10]
                end
            end
            prs_pkg::PRS_DEV_SRST: begin
                s_d.dir = 1'b0; // [RULE11]
                s_d.cnt = s_q.cnt - 16'h0001;
                if (s_q.cnt == 16'h0001) begin
                    s_d.st = prs_pkg::PRS_DEV_RXCMD;
                    s_d.core_rst_n = 1'b1;
                    s_d.dir = 1'b1;
                end
            end
            prs_pkg::PRS_DEV_RXCMD: begin
                s_d.dir = 1'b1; // [RULE11]
                s_d.data = s_q.rxcmd;
                s_d.data_oe = 1'b1;
                s_d.st = prs_pkg::PRS_DEV_IDLE;
            end
        endcase
        if (!logic_srst_n) begin
            s_d.st = prs_pkg::PRS_DEV_IDLE;
            s_d.core_rst_n = 1'b0;
            s_d.dir = 1'b0;
        end
        s_d.busy = (s_d.st == prs_pkg::PRS_DEV_SRST);
        if (!s_q.oe_sync[1] || !logic_srst_n) begin
            s_d.data_oe = 1'b0; // [RULE14]
        end
        s_d.dir_pin = s_d.dir & s_q.oe_sync[1]; // [RULE14]
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge chip_srst_n) begin
        if (!chip_srst_n) begin
            s_q <= '{st: prs_pkg::PRS_DEV_IDLE, cnt: 16'h0000, strap: `PRS_STRAP_DEFAULT,
                     rxcmd: `PRS_RXCMD_DEFAULT, dir: 1'b0, data_oe: 1'b0, data: 8'h00,
                     core_rst_n: 1'b0, oe_sync: 2'h0, strap_s1: 6'h00, strap_s2: 6'h00,
                     wr_sync: 2'h0, wr_last: 1'b0, run: 3'h0, dir_pin: 1'b0,
                     busy: 1'b0}; // [RULE1]
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.strap_i = strap_pad;
    assign link.ulpi_direction = s_q.dir_pin; // [RULE14]
    assign link.ulpi_data_bus = s_q.data;
    assign link.ulpi_data_oe = s_q.data_oe;
    assign strap_cfg = s_q.strap;
    assign core_reset_n = s_q.core_rst_n;
    assign srst_busy = s_q.busy;
endmodule

/* File: rtl/prs_host.sv */
`timescale 1ns/1ps
`include "prs_consts.svh"
module prs_host (
    input wire logic mclk,
    input wire logic rst_n,
    prs_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef struct packed {
        prs_pkg::prs_host_state_type st;
        logic chip_rst_n;
        logic logic_rst_n;
        logic out_en;
        logic [5:0] strap_val;
        logic [5:0] strap_en;
        logic swing;
        logic term;
        logic srst_req;
        logic [1:0] dir_sync;
        logic dir_low;
        logic ready;
        logic err;
        logic [31:0] rdata;
    } prs_host_ctl_type;

    prs_host_ctl_type h_q;
    prs_host_ctl_type h_d;
    logic access;

    assign access = psel & penable & ~h_q.ready;

    // ------------------------------------------------------------
    // APB slave and sequencing
    // ------------------------------------------------------------
    always_comb begin
        h_d = h_q;
        h_d.ready = 1'b0;
        h_d.err = 1'b0;
        h_d.dir_sync = {h_q.dir_sync[0], link.ulpi_direction};
        if (access) begin
            h_d.ready = 1'b1;
            h_d.rdata = 32'h0000_0000;
            unique case (paddr)
                `PRS_APB_CTRL: begin
                    if (pwrite) begin
                        h_d.chip_rst_n = pwdata[0];
                        h_d.logic_rst_n = pwdata[1];
                        h_d.out_en = pwdata[2];
                        if (pwdata[3] && h_q.st == prs_pkg::PRS_HOST_RUN) begin
                            h_d.srst_req = 1'b1;
                            h_d.dir_low = 1'b0;
                            h_d.st = prs_pkg::PRS_HOST_WAIT;
                        end
                    end
                    h_d.rdata = {28'h0, 1'b0, h_q.out_en, h_q.logic_rst_n, h_q.chip_rst_n};
                end
                `PRS_APB_STATUS: begin
                    h_d.rdata = {29'h0, h_q.dir_sync[1], h_q.st == prs_pkg::PRS_HOST_WAIT,
                                 h_q.st == prs_pkg::PRS_HOST_HOLD};
                end
                `PRS_APB_STRAP: begin
                    if (pwrite) begin
                        h_d.strap_val = pwdata[5:0]; // [RULE4]
                        h_d.strap_en = pwdata[13:8]; // [RULE6]
                    end
                    h_d.rdata = {18'h0, h_q.strap_en, 2'h0, h_q.strap_val};
                end
                `PRS_APB_BOARD: begin
                    if (pwrite) begin
                        h_d.swing = pwdata[0]; // [RULE8]
                        h_d.term = pwdata[1];
                    end
                    h_d.rdata = {30'h0, h_q.term, h_q.swing};
                end
                default: begin
                    h_d.err = 1'b1;
                end
            endcase
        end
        unique case (h_q.st)
            prs_pkg::PRS_HOST_HOLD: begin
                // Chip reset is software's to release, only once power is up.
                if (h_q.chip_rst_n) begin
                    h_d.st = prs_pkg::PRS_HOST_RUN; // [RULE2] [RULE3]
                end
            end
            prs_pkg::PRS_HOST_RUN: begin
            end
            prs_pkg::PRS_HOST_WAIT: begin
                h_d.srst_req = 1'b0; // [RULE9]
                if (!h_q.dir_sync[1]) begin
                    h_d.dir_low = 1'b1;
                end
                // Direction may still stand high from an earlier reset; only low then high ends it.
                if (h_q.dir_low && h_q.dir_sync[1]) begin
                    h_d.st = prs_pkg::PRS_HOST_RUN; // [RULE12]
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            h_q <= '{st: prs_pkg::PRS_HOST_HOLD, chip_rst_n: 1'b0, logic_rst_n: 1'b1,
                     out_en: 1'b0, strap_val: 6'h00, strap_en: 6'h00, swing: 1'b0,
                     term: 1'b0, srst_req: 1'b0, dir_sync: 2'h0, dir_low: 1'b0,
                     ready: 1'b0, err: 1'b0,
                     rdata: 32'h0000_0000}; // [RULE13]
        end else begin
            h_q <= h_d;
        end
    end

    // ------------------------------------------------------------
    // Link pins
    // ------------------------------------------------------------
    always_comb begin
        link.chip_reset_n = h_q.chip_rst_n;
        link.logic_reset_n = h_q.logic_rst_n;
        link.out_enable = h_q.out_en;
        link.strap_o = h_q.strap_val;
        // Straps stay driven past release, since the device samples them a few edges later.
        link.strap_oe = h_q.strap_en; // [RULE4]
        link.srst_write = h_q.srst_req;
        link.detect_loopback_req = 1'b0; // [RULE7]
        link.tx_idle_req = 1'b1;
        link.compliance_req = 1'b0;
        link.rx_polarity_req = 1'b0;
        link.power_select = `PRS_PWR_RESET;
        link.tx_level_margin = `PRS_MARGIN_RESET;
        link.deemphasis_sel = 1'b1; // [RULE8]
        link.rate_sel = 1'b1;
        link.tx_swing_sel = h_q.swing;
        link.rx_term_ctrl = h_q.term;
    end
    assign prdata = h_q.rdata;
    assign pready = h_q.ready;
    assign pslverr = h_q.err;
endmodule

/* File: verif/prs_link_asserts.sv */
`timescale 1ns/1ps
`include "prs_consts.svh"
module prs_link_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic chip_reset_n,
    input wire logic out_enable,
    input wire logic srst_write,
    input wire logic ulpi_direction,
    input wire logic [7:0] ulpi_data_bus,
    input wire logic ulpi_data_oe,
    input wire logic detect_loopback_req,
    input wire logic tx_idle_req,
    input wire logic compliance_req,
    input wire logic rx_polarity_req,
    input wire logic [1:0] power_select,
    input wire logic [2:0] tx_level_margin,
    input wire logic deemphasis_sel,
    input wire logic rate_sel
);
    // ----------------------------------------
    // Link checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    reset_levels_a: assert property (!chip_reset_n |-> !detect_loopback_req && tx_idle_req
        && !compliance_req && !rx_polarity_req && power_select == 2'h2 && tx_level_margin == 3'h0)
        else $error("Control levels wrong in chip reset.");
    rate_levels_a: assert property (!chip_reset_n |-> deemphasis_sel && rate_sel)
        else $error("Rate or de-emphasis wrong in chip reset.");
    power_up_a: assert property ($rose(rst_n) |-> !out_enable && !chip_reset_n)
        else $error("Outputs or chip reset not held at power-up.");
    reset_quiet_a: assert property (!chip_reset_n |-> !ulpi_direction && !ulpi_data_oe)
        else $error("Device active in chip reset.");
    // The enable passes two flip-flops and a register, so only a low of three edges is judged.
    drive_gate_a: assert property (!out_enable && !$past(out_enable)
        && !$past(out_enable, 2) |-> !ulpi_data_oe)
        else $error("Bus driven with outputs disabled.");
    // A rise that only follows the return of output enable carries no status update.
    rxcmd_after_a: assert property ($rose(ulpi_direction) && out_enable
        && $past(out_enable, 4) |=> ulpi_data_oe && ulpi_data_bus == `PRS_RXCMD_DEFAULT)
        else $error("No status update after reset.");
    srst_len_a: assert property ($rose(ulpi_direction) |-> !$past(ulpi_direction, 2))
        else $error("Direction low too briefly.");
    oe_dir_a: assert property (ulpi_data_oe |-> ulpi_direction)
        else $error("Bus driven without direction.");
    write_pulse_a: assert property ($rose(srst_write) |=> !srst_write)
        else $error("Soft reset request not a pulse.");
endmodule

/* File: verif/test_phy_reset_sequencing.sv */
`timescale 1ns/1ps
module test_phy_reset_sequencing;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] sv;
    logic pready, pslverr, core_reset_n, srst_busy;
    logic [5:0] strap_cfg;
    logic [31:0] exp_d[$];
    logic [31:0] exp_m[$];
    logic exp_e[$];
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    prs_link_if link ();
    prs_host i_prs_host (.mclk(mclk), .rst_n(rst_n), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    prs_device #(.SRST_CYCLES(2)) i_prs_device (.mclk(mclk), .rst_n(rst_n), .link(link),
        .strap_cfg(strap_cfg), .core_reset_n(core_reset_n), .srst_busy(srst_busy));
    prs_link_asserts i_prs_link_asserts (.mclk(mclk), .rst_n(rst_n),
        .chip_reset_n(link.chip_reset_n), .out_enable(link.out_enable),
        .srst_write(link.srst_write), .ulpi_direction(link.ulpi_direction),
        .ulpi_data_bus(link.ulpi_data_bus), .ulpi_data_oe(link.ulpi_data_oe),
        .detect_loopback_req(link.detect_loopback_req), .tx_idle_req(link.tx_idle_req),
        .compliance_req(link.compliance_req), .rx_polarity_req(link.rx_polarity_req),
        .power_select(link.power_select), .tx_level_margin(link.tx_level_margin),
        .deemphasis_sel(link.deemphasis_sel), .rate_sel(link.rate_sel));

    // ----------------------------------------
    // Clock, timeout and reporting
    // ----------------------------------------
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1) begin
            check("prdata", prdata & exp_m[0], exp_d[0] & exp_m[0]);
            check("pslverr", {31'h0, pslverr}, {31'h0, exp_e[0]});
            void'(exp_d.pop_front());
            void'(exp_m.pop_front());
            void'(exp_e.pop_front());
        end
    end

    // ----------------------------------------
    // Bus and sequence tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        exp_d.push_back(d);
        exp_m.push_back(wr ? 32'h0 : m);
        exp_e.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wait_core(input logic lvl);
        for (n = 0; n < 50 && core_reset_n !== lvl; n++) @(posedge mclk);
    endtask
    // Straps are set while chip reset is held, then a changed write must not reach the latch.
    task automatic strap_cycle();
        sv = $urandom & 32'h3f3f;
        apb(1'b1, 12'h008, sv, 32'h0, 1'b0);
        apb(1'b1, 12'h000, 32'h7, 32'h0, 1'b0);
        wait_core(1'b1);
        check("strap_cfg", {26'h0, strap_cfg}, {26'h0, sv[5:0] & sv[13:8]});
        apb(1'b1, 12'h008, ~sv & 32'h3f3f, 32'h0, 1'b0);
        check("strap_hold", {26'h0, strap_cfg}, {26'h0, sv[5:0] & sv[13:8]});
    endtask

    initial begin
        n = $urandom(32'h2cbd);
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        apb(1'b0, 12'h000, 32'h2, 32'hf, 1'b0);
        apb(1'b0, 12'h004, 32'h1, 32'h7, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
        sv = $urandom & 32'h3;
        apb(1'b1, 12'h00c, sv, 32'h0, 1'b0);
        apb(1'b0, 12'h00c, sv, 32'h3, 1'b0);
        strap_cycle();
        apb(1'b1, 12'h000, 32'h5, 32'h0, 1'b0);
        wait_core(1'b0);
        check("logic_reset", {31'h0, core_reset_n}, 32'h0);
        apb(1'b1, 12'h000, 32'h7, 32'h0, 1'b0);
        wait_core(1'b1);
        apb(1'b1, 12'h000, 32'hf, 32'h0, 1'b0);
        for (n = 0; n < 50 && srst_busy !== 1'b1; n++) @(posedge mclk);
        check("dir_in_srst", {31'h0, link.ulpi_direction}, 32'h0);
        check("core_in_srst", {31'h0, core_reset_n}, 32'h0);
        for (n = 0; n < 50 && link.ulpi_direction !== 1'b1; n++) @(posedge mclk);
        check("dir_after", {31'h0, link.ulpi_direction}, 32'h1);
        check("strap_kept", {26'h0, strap_cfg}, {26'h0, sv[5:0] & sv[13:8]});
        repeat (4) @(posedge mclk);
        apb(1'b0, 12'h004, 32'h4, 32'h6, 1'b0);
        apb(1'b1, 12'h000, 32'h3, 32'h0, 1'b0);
        repeat (4) @(posedge mclk);
        check("dir_gated", {31'h0, link.ulpi_direction}, 32'h0);
        apb(1'b1, 12'h000, 32'h7, 32'h0, 1'b0);
        repeat (4) @(posedge mclk);
        check("dir_back", {31'h0, link.ulpi_direction}, 32'h1);
        apb(1'b1, 12'h000, 32'h6, 32'h0, 1'b0);
        check("chip_reset", {31'h0, core_reset_n}, 32'h0);
        strap_cycle();
        final_report();
    end
endmodule
